// ---- hw/cst_regs.sv ----
// register group and swap sequencer for core swap timing and termination trims
// assumes fuse values are stable while fuse_load is high, and one clock for everything
//
// The plain strobed port was left to the implementer.
module cst_regs
   import cst_pkg::*;
(
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire cst_pkg::cst_bus_t bus,
   input  wire cst_pkg::cst_trim_t fuse_trim,
   input  wire logic             fuse_load,
   input  wire logic             swap_req,
   output logic [cst_pkg::DATA_W-1:0] rdata,
   output cst_pkg::cst_trim_t    trim_out,
   output logic [cst_pkg::DATA_W-1:0] dither_out,
   output logic                  overlap_active,
   output logic                  mux_sel,
   output logic                  swap_busy
);
   import cst_pkg::*;

   typedef struct packed {
      cst_trim_t         trim;
      logic [DLY_W-1:0]  overlap;
      logic [DLY_W-1:0]  muxsel;
      logic [DATA_W-1:0] dither;
      logic [DATA_W-1:0] rdata;
      cst_state_t        state;
      logic [CNT_W-1:0]  cnt;
      logic [DLY_W-1:0]  lat_muxsel;
      logic              overlap_on;
      logic              sel;
      logic              busy;
   } cst_st_t;

   cst_st_t s_reg;
   cst_st_t s_next;

   // one flag per mapped register; unmapped addresses leave all flags low
   typedef struct packed {
      logic trim_b;
      logic trim_c;
      logic trim_d;
      logic overlap;
      logic muxsel;
      logic dither;
   } cst_hit_t;

   // address decode shared by the write path, the read path and the checks
   function automatic cst_hit_t reg_hit(input logic [ADDR_W-1:0] a);
      cst_hit_t h;
      h = '0;
      if (a == TRIM_B_ADDR) begin
         h.trim_b = 1'b1;
      end else if (a == TRIM_C_ADDR) begin
         h.trim_c = 1'b1;
      end else if (a == TRIM_D_ADDR) begin
         h.trim_d = 1'b1;
      end else if (a == OVERLAP_ADDR) begin
         h.overlap = 1'b1;
      end else if (a == MUXSEL_ADDR) begin
         h.muxsel = 1'b1;
      end else if (a == DITHER_ADDR) begin
         h.dither = 1'b1;
      end
      return h;
   endfunction

   // decoded once so write and read paths can never disagree on the map
   cst_hit_t hit;
   assign hit = reg_hit(bus.addr);

   // register access, fuse preload and swap sequencing
   always_comb begin
      s_next = s_reg;
      s_next.rdata = READ_NONE;
      if (fuse_load) begin
         s_next.trim = fuse_trim;
      end else if (bus.wr) begin
         if (hit.trim_b) begin
            s_next.trim.trim_b = bus.wdata;
         end else if (hit.trim_c) begin
            s_next.trim.trim_c = bus.wdata;
         end else if (hit.trim_d) begin
            s_next.trim.trim_d = bus.wdata;
         end else if (hit.overlap) begin
            s_next.overlap = bus.wdata[DLY_W-1:0];
         end else if (hit.muxsel) begin
            s_next.muxsel = bus.wdata[DLY_W-1:0];
         end else if (hit.dither) begin
            s_next.dither = bus.wdata;
         end
      end
      // reserved bits 7:5 of the overlap and mux delay registers always read back zero
      if (bus.rd) begin
         if (hit.trim_b) begin
            s_next.rdata = s_reg.trim.trim_b;
         end else if (hit.trim_c) begin
            s_next.rdata = s_reg.trim.trim_c;
         end else if (hit.trim_d) begin
            s_next.rdata = s_reg.trim.trim_d;
         end else if (hit.overlap) begin
            s_next.rdata = {3'h0, s_reg.overlap};
         end else if (hit.muxsel) begin
            s_next.rdata = {3'h0, s_reg.muxsel};
         end else if (hit.dither) begin
            s_next.rdata = s_reg.dither;
         end
      end
      // delays are sampled only at swap start, so edits never tear a swap
      case (s_reg.state)
         ST_IDLE: begin
            if (swap_req) begin
               s_next.state      = ST_OVERLAP;
               s_next.cnt        = overlap_len(s_reg.overlap);
               s_next.lat_muxsel = s_reg.muxsel;
               s_next.overlap_on = 1'b1;
            end
         end
         ST_OVERLAP: begin
            if (s_reg.cnt == CNT_ONE) begin
               s_next.overlap_on = 1'b0;
               s_next.state      = ST_MUXWAIT;
               s_next.cnt        = {2'b00, s_reg.lat_muxsel};
            end else begin
               s_next.cnt = s_reg.cnt - CNT_ONE;
            end
         end
         ST_MUXWAIT: begin
            // mux flips after the programmed extra delay, only inside a swap
            if (s_reg.cnt == CNT_ZERO) begin
               s_next.sel   = ~s_reg.sel;
               s_next.state = ST_IDLE;
            end else begin
               s_next.cnt = s_reg.cnt - CNT_ONE;
            end
         end
         default: s_next.state = ST_IDLE;
      endcase
      // busy is registered so the output comes straight from a flop
      s_next.busy = (s_next.state != ST_IDLE);
   end

   // single state register, reset to documented defaults
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_reg            <= '0;
         s_reg.overlap    <= OVERLAP_RST;
         s_reg.muxsel     <= MUXSEL_RST;
         s_reg.dither     <= DITHER_RST;
         s_reg.state      <= ST_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   assign rdata          = s_reg.rdata;
   assign trim_out       = s_reg.trim;
   assign dither_out     = s_reg.dither;
   assign overlap_active = s_reg.overlap_on;
   assign mux_sel        = s_reg.sel;
   assign swap_busy      = s_reg.busy;

   // helper: count overlap cycles of the current swap
   logic [CNT_W-1:0] ov_cnt;
   logic [CNT_W-1:0] ov_len;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ov_cnt <= CNT_ZERO;
         ov_len <= CNT_ZERO;
      end else if (s_reg.state == ST_IDLE && swap_req) begin
         ov_cnt <= CNT_ZERO;
         ov_len <= overlap_len(s_reg.overlap);
      end else if (s_reg.overlap_on) begin
         ov_cnt <= ov_cnt + CNT_ONE;
      end
   end

   sequence swap_start_s;
      s_reg.state == ST_IDLE && swap_req;
   endsequence

   overlap_len_a: assert property (@(posedge clock) disable iff (!rst_n)
      $fell(s_reg.overlap_on) |-> ov_cnt == ov_len)
      else $error("overlap length differs from four plus twice the setting");
   overlap_rise_a: assert property (@(posedge clock) disable iff (!rst_n)
      swap_start_s |=> s_reg.overlap_on)
      else $error("overlap did not begin at swap start");
   mux_idle_a: assert property (@(posedge clock) disable iff (!rst_n)
      $changed(s_reg.sel) |-> $past(s_reg.state) == ST_MUXWAIT)
      else $error("mux select moved outside a swap");
   mux_delay_a: assert property (@(posedge clock) disable iff (!rst_n)
      $fell(s_reg.overlap_on) && s_reg.lat_muxsel == 5'h00 |=> $changed(s_reg.sel))
      else $error("mux select with zero delay did not flip at once");
   latch_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
      swap_busy && $past(swap_busy) |-> $stable(s_reg.lat_muxsel))
      else $error("latched mux delay changed mid swap");
   trim_fuse_a: assert property (@(posedge clock) disable iff (!rst_n)
      fuse_load |=> trim_out == $past(fuse_trim))
      else $error("trim did not load fuse value");
   overlap_wr_a: assert property (@(posedge clock) disable iff (!rst_n)
      bus.wr && !fuse_load && bus.addr == OVERLAP_ADDR |=>
         s_reg.overlap == $past(bus.wdata[DLY_W-1:0]))
      else $error("overlap delay write lost");
   reserved_rd_a: assert property (@(posedge clock) disable iff (!rst_n)
      bus.rd && (bus.addr == MUXSEL_ADDR || bus.addr == OVERLAP_ADDR) |=> rdata[7:5] == 3'h0)
      else $error("reserved delay bits read nonzero");

   // helper: count mux wait cycles of the current swap
   logic [CNT_W-1:0] mx_cnt;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mx_cnt <= CNT_ZERO;
      end else if (s_reg.state == ST_OVERLAP && s_reg.cnt == CNT_ONE) begin
         mx_cnt <= CNT_ZERO;
      end else if (s_reg.state == ST_MUXWAIT) begin
         mx_cnt <= mx_cnt + CNT_ONE;
      end
   end

   // last overlap cycle, and last mux wait cycle
   sequence overlap_end_s;
      s_reg.state == ST_OVERLAP && s_reg.cnt == CNT_ONE;
   endsequence

   sequence mux_flip_s;
      s_reg.state == ST_MUXWAIT && s_reg.cnt == CNT_ZERO;
   endsequence

   // swap sequencing: overlap, then mux wait, then one flip
   overlap_end_a: assert property (@(posedge clock) disable iff (!rst_n)
      overlap_end_s |=> !s_reg.overlap_on && s_reg.state == ST_MUXWAIT)
      else $error("overlap did not end on its last count");

   overlap_state_a: assert property (@(posedge clock) disable iff (!rst_n)
      s_reg.overlap_on |-> s_reg.state == ST_OVERLAP)
      else $error("overlap active outside the overlap state");

   busy_start_a: assert property (@(posedge clock) disable iff (!rst_n)
      swap_start_s |=> swap_busy && s_reg.cnt == ov_len)
      else $error("swap start did not load the overlap count");

   // the count can never exceed what was latched at swap start
   overlap_lock_a: assert property (@(posedge clock) disable iff (!rst_n)
      s_reg.state == ST_OVERLAP |-> s_reg.cnt <= ov_len)
      else $error("overlap count exceeds the latched length");

   mux_span_a: assert property (@(posedge clock) disable iff (!rst_n)
      $changed(s_reg.sel) |-> mx_cnt == {2'b00, s_reg.lat_muxsel} + CNT_ONE)
      else $error("mux select delay differs from the latched setting");

   mux_flip_a: assert property (@(posedge clock) disable iff (!rst_n)
      mux_flip_s |=> $changed(s_reg.sel) && !swap_busy)
      else $error("mux select did not flip at the end of the wait");

   one_flip_a: assert property (@(posedge clock) disable iff (!rst_n)
      $changed(s_reg.sel) |-> !swap_busy)
      else $error("mux select flipped while the swap still runs");

   // register writes land in the addressed field only
   muxsel_wr_a: assert property (@(posedge clock) disable iff (!rst_n)
      bus.wr && !fuse_load && hit.muxsel |=> s_reg.muxsel == $past(bus.wdata[DLY_W-1:0]))
      else $error("mux delay write lost");

   trim_b_wr_a: assert property (@(posedge clock) disable iff (!rst_n)
      bus.wr && !fuse_load && hit.trim_b |=> trim_out.trim_b == $past(bus.wdata))
      else $error("trim b write lost");

   trim_c_wr_a: assert property (@(posedge clock) disable iff (!rst_n)
      bus.wr && !fuse_load && hit.trim_c |=> trim_out.trim_c == $past(bus.wdata))
      else $error("trim c write lost");

   trim_d_wr_a: assert property (@(posedge clock) disable iff (!rst_n)
      bus.wr && !fuse_load && hit.trim_d |=> trim_out.trim_d == $past(bus.wdata))
      else $error("trim d write lost");

   trim_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
      !fuse_load && !bus.wr |=> $stable(trim_out))
      else $error("trim changed without a write or fuse load");

   // delays only move on their own write, never during a swap by themselves
   delay_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
      !(bus.wr && (hit.overlap || hit.muxsel)) |=> $stable(s_reg.overlap) && $stable(s_reg.muxsel))
      else $error("delay setting changed without a write");

   // read data stands for one cycle only, zero otherwise
   trim_rd_a: assert property (@(posedge clock) disable iff (!rst_n)
      bus.rd && hit.trim_c |=> rdata == $past(trim_out.trim_c))
      else $error("trim c read returned a wrong value");

   overlap_rd_a: assert property (@(posedge clock) disable iff (!rst_n)
      bus.rd && hit.overlap |=> rdata[DLY_W-1:0] == $past(s_reg.overlap))
      else $error("overlap delay read returned a wrong value");

   rd_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
      !bus.rd |=> rdata == READ_NONE)
      else $error("read data present without a read");
endmodule // cst_regs

// ---- inc/cst_pkg.sv ----
// constants, register map and carrier types for the core swap timing and trim registers
// assumes a single clock domain and a plain strobe register port
package cst_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int DLY_W  = 5;
   localparam int CNT_W  = 7;

   localparam logic [ADDR_W-1:0] TRIM_B_ADDR  = 12'h07F;
   localparam logic [ADDR_W-1:0] TRIM_C_ADDR  = 12'h080;
   localparam logic [ADDR_W-1:0] TRIM_D_ADDR  = 12'h081;
   localparam logic [ADDR_W-1:0] OVERLAP_ADDR = 12'h09A;
   localparam logic [ADDR_W-1:0] MUXSEL_ADDR  = 12'h09B;
   localparam logic [ADDR_W-1:0] DITHER_ADDR  = 12'h09D;

   localparam logic [DLY_W-1:0]  OVERLAP_RST  = 5'h08;
   localparam logic [DLY_W-1:0]  MUXSEL_RST   = 5'h07;
   localparam logic [DATA_W-1:0] DITHER_RST   = 8'h00;
   localparam logic [DATA_W-1:0] READ_NONE    = 8'h00;
   localparam logic [CNT_W-1:0]  OVERLAP_BASE = 7'h04;
   localparam logic [CNT_W-1:0]  CNT_ONE      = 7'h01;
   localparam logic [CNT_W-1:0]  CNT_ZERO     = 7'h00;

   typedef enum logic [1:0] {ST_IDLE, ST_OVERLAP, ST_MUXWAIT} cst_state_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } cst_bus_t;

   typedef struct packed {
      logic [DATA_W-1:0] trim_b;
      logic [DATA_W-1:0] trim_c;
      logic [DATA_W-1:0] trim_d;
   } cst_trim_t;

   // overlap length in conversion clock cycles: 4 + 2*value
   function automatic logic [CNT_W-1:0] overlap_len(input logic [DLY_W-1:0] v);
      return OVERLAP_BASE + {1'b0, v, 1'b0};
   endfunction
endpackage : cst_pkg

// ---- testbench/tb_top.sv ----
// self-checking bench for the swap timing and termination trim register group
// assumes reads answer one cycle later and the register port never stalls
module tb_top
   import cst_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic              clock, rst_n, fuse_load, swap_req, rd_seen, ms;
   cst_bus_t          bus;
   cst_trim_t         fuse_trim, trim_out;
   logic [DATA_W-1:0] rdata, dither_out, lf, d;
   logic              overlap_active, mux_sel, swap_busy;
   logic [DATA_W-1:0] q[$];
   int                n_mismatch, n_checks;
   logic [ADDR_W-1:0] am[7] = '{TRIM_B_ADDR, TRIM_C_ADDR, TRIM_D_ADDR, OVERLAP_ADDR,
                                MUXSEL_ADDR, DITHER_ADDR, 12'h0FF};
   logic [DATA_W-1:0] rv[7] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h07, 8'h00, 8'h00};

   cst_regs u_dut (.clock(clock), .rst_n(rst_n), .bus(bus), .fuse_trim(fuse_trim),
      .fuse_load(fuse_load), .swap_req(swap_req), .rdata(rdata), .trim_out(trim_out),
      .dither_out(dither_out), .overlap_active(overlap_active), .mux_sel(mux_sel),
      .swap_busy(swap_busy));

   // clock generation, 100 ns period
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   function automatic logic [7:0] lfsr();
      lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
      return lf;
   endfunction

   task chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task end_of_test;
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // one access per cycle; reads note the expected answer
   task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] dat,
                      input logic [7:0] e);
      bus <= '{addr: a, wdata: dat, wr: w, rd: !w};
      if (!w) q.push_back(e);
      @(posedge clock);
   endtask

   task idle;
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
   endtask

   // read answers are taken at the falling edge, well after they settle
   always @(posedge clock) rd_seen <= bus.rd;
   always @(negedge clock) if (rd_seen === 1'b1) chk(rdata, q.pop_front());

   // one swap; optional mux delay rewrite while it runs must not disturb it
   // the overlap delay itself is never touched while a swap runs
   task automatic swap(input int v, input int m, input logic mid);
      int n;
      chk(mux_sel, ms);
      swap_req <= 1'b1;
      @(posedge clock);
      swap_req <= 1'b0;
      bus <= '{addr: MUXSEL_ADDR, wdata: 8'h1F, wr: mid, rd: 1'b0};
      @(posedge clock);
      idle;
      n = 1;
      @(negedge clock);
      while (overlap_active === 1'b1 && n < 200) begin
         n++;
         @(negedge clock);
      end
      chk(n, 4 + 2 * v);
      n = 0;
      while (mux_sel === ms && n < 100) begin
         n++;
         @(negedge clock);
      end
      chk(n, m + 1);
      chk(swap_busy, 0);
      ms = mux_sel;
      @(posedge clock);
   endtask

   initial begin
      rst_n = 1'b0; fuse_load = 1'b0; swap_req = 1'b0; bus = '0; fuse_trim = '0;
      lf = 8'h1A; ms = 1'b0;
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      for (int i = 0; i < 7; i++) acc(0, am[i], 8'h00, rv[i]);
      idle;
      // factory values arrive on the fuse load pulse
      fuse_trim <= {lfsr(), lfsr(), lfsr()};
      fuse_load <= 1'b1;
      @(posedge clock);
      fuse_load <= 1'b0;
      @(posedge clock);
      chk(trim_out, fuse_trim);
      acc(0, TRIM_B_ADDR, 8'h00, fuse_trim.trim_b);
      acc(0, TRIM_D_ADDR, 8'h00, fuse_trim.trim_d);
      // back-to-back write and read; delay writes keep reserved bits clear
      for (int i = 0; i < 7; i++) begin
         d = lfsr();
         acc(1, am[i], (i == 3 || i == 4) ? (d & 8'h1F) : d, 8'h00);
         acc(0, am[i], 8'h00, (i == 6) ? 8'h00 : (i == 3 || i == 4) ? (d & 8'h1F) : d);
      end
      acc(1, DITHER_ADDR, 8'hA5, 8'h00);
      acc(1, OVERLAP_ADDR, 8'h00, 8'h00);
      acc(1, MUXSEL_ADDR, 8'h00, 8'h00);
      idle;
      swap(0, 0, 1'b1);
      acc(0, MUXSEL_ADDR, 8'h00, 8'h1F);
      acc(1, OVERLAP_ADDR, 8'h1F, 8'h00);
      idle;
      swap(31, 31, 1'b0);
      acc(1, OVERLAP_ADDR, 8'h07, 8'h00);
      acc(1, MUXSEL_ADDR, 8'h07, 8'h00);
      idle;
      swap(7, 7, 1'b0);
      repeat (3) @(posedge clock);
      chk(dither_out, 8'hA5);
      end_of_test;
   end

   // cut a hang short, far beyond the expected run length
   initial begin
      #2000000;
      n_mismatch++;
      end_of_test;
   end
endmodule // tb_top
